// ==== logic/hslm_lane_sel.sv ====
// Purpose: decode one lane's selection into a legal source route
// Assumes: LANE is the fixed lane number 0..3
// Notes:   purely combinational; the top registers the result
module hslm_lane_sel
  import hslm_pkg::*;
#(
  parameter int LANE = 0
) (
  input  wire hslm_sel_e   sel_i,
  input  wire logic [1:0]  pcie_width_i,
  output hslm_route_s      route_o
);

  localparam logic [`HSLM_SRC_W-1:0] LANE_N = `HSLM_SRC_W'(LANE);
  localparam logic [`HSLM_SRC_W-1:0] LANE_P = `HSLM_SRC_W'(LANE % 2);

  always_comb begin
    route_o = '0;
    case (sel_i)
      HSLM_SEL_PCIE: begin
        if (LANE < int'(hslm_pcie_lanes(pcie_width_i))) begin
          route_o.ok    = 1'b1;
          route_o.rx_ok = 1'b1;
          route_o.src   = `HSLM_SRC_PCIE + LANE_N;
        end
      end
      HSLM_SEL_SATA: begin
        route_o.ok    = 1'b1;
        route_o.rx_ok = 1'b1;
        route_o.src   = `HSLM_SRC_SATA + LANE_P;
      end
      HSLM_SEL_DISP: begin
        // transmit only, so rx stays unrouted
        route_o.ok  = 1'b1;
        route_o.src = `HSLM_SRC_DISP + (LANE_P ^ 4'h1);
      end
      HSLM_SEL_USB0: begin
        if (LANE <= `HSLM_USB0_LAST) begin
          route_o.ok    = 1'b1;
          route_o.rx_ok = 1'b1;
          route_o.src   = `HSLM_SRC_USB;
        end
      end
      HSLM_SEL_USB1: begin
        if (LANE == `HSLM_USB1_LANE) begin
          route_o.ok    = 1'b1;
          route_o.rx_ok = 1'b1;
          route_o.src   = `HSLM_SRC_USB + 4'h1;
        end
      end
      HSLM_SEL_SGMII: begin
        route_o.ok    = 1'b1;
        route_o.rx_ok = 1'b1;
        route_o.src   = `HSLM_SRC_SGMII + LANE_N;
      end
      default: route_o = '0;
    endcase
  end

endmodule : hslm_lane_sel

// ==== logic/hslm_map.svh ====
// Purpose: constants of the high-speed lane multiplexer
// Assumes: included by the package; the design modules rely on its macros
// Notes:   source numbering is shared by route decode and rx return
`ifndef HSLM_MAP_SVH
`define HSLM_MAP_SVH

`define HSLM_LANES      4
`define HSLM_DATA_W     20
`define HSLM_SRC_W      4
`define HSLM_SRC_COUNT  14
`define HSLM_SRC_PCIE   4'h0
`define HSLM_SRC_SATA   4'h4
`define HSLM_SRC_DISP   4'h6
`define HSLM_SRC_USB    4'h8
`define HSLM_SRC_SGMII  4'hA
`define HSLM_WIDTH_X1   2'h0
`define HSLM_WIDTH_X2   2'h1
`define HSLM_WIDTH_X4   2'h2
`define HSLM_USB0_LAST  2
`define HSLM_USB1_LANE  3

`endif

// ==== logic/hslm_pkg.sv ====
// Purpose: types of the high-speed lane multiplexer
// Assumes: hslm_map.svh supplies widths
// Notes:   an all-zero symbol is the idle lane pattern
`include "hslm_map.svh"

package hslm_pkg;

  typedef enum logic [2:0] {
    HSLM_SEL_NONE,
    HSLM_SEL_PCIE,
    HSLM_SEL_SATA,
    HSLM_SEL_DISP,
    HSLM_SEL_USB0,
    HSLM_SEL_USB1,
    HSLM_SEL_SGMII
  } hslm_sel_e;

  typedef struct packed {
    logic                    vld;
    logic [`HSLM_DATA_W-1:0] dat;
  } hslm_sym_s;

  typedef struct packed {
    logic                   ok;
    logic                   rx_ok;
    logic [`HSLM_SRC_W-1:0] src;
  } hslm_route_s;

  function automatic logic [2:0] hslm_pcie_lanes(input logic [1:0] width);
    case (width)
      `HSLM_WIDTH_X1: hslm_pcie_lanes = 3'h1;
      `HSLM_WIDTH_X2: hslm_pcie_lanes = 3'h2;
      `HSLM_WIDTH_X4: hslm_pcie_lanes = 3'h4;
      default:        hslm_pcie_lanes = 3'h0;
    endcase
  endfunction : hslm_pcie_lanes

endpackage : hslm_pkg

// ==== logic/hslm_top.sv ====
// Purpose: route high-speed peripherals onto four transceiver lanes
// Assumes: selection inputs are quasi-static configuration
// Notes:   one cycle of latency each way; illegal pairings idle the lane
//
// Overview of operation
// - each peripheral reaches a lane only as configuration selects
// - four lanes, 0 to 3, each carrying one peripheral at a time
// - pcie lane n sits on lane n below the x1/x2/x4 width
// - sata channel 0 on lanes 0 or 2, channel 1 on 1 or 3
// - display transmit only; second lane on 0/2, first on 1/3
// - first usb controller only on lanes 0, 1 or 2
// - several protocols at once on different lanes, freely programmed
module hslm_top
  import hslm_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire hslm_sel_e [3:0]    lane_sel_i,
  input  wire logic [1:0]         pcie_width_i,
  input  wire hslm_sym_s [3:0]    pcie_tx_i,
  input  wire hslm_sym_s [1:0]    sata_tx_i,
  input  wire hslm_sym_s [1:0]    disp_tx_i,
  input  wire hslm_sym_s [1:0]    usb_tx_i,
  input  wire hslm_sym_s [3:0]    sgmii_tx_i,
  input  wire hslm_sym_s [3:0]    lane_rx_i,
  output hslm_sym_s [3:0]         lane_tx_o,
  output hslm_sym_s [3:0]         pcie_rx_o,
  output hslm_sym_s [1:0]         sata_rx_o,
  output hslm_sym_s [1:0]         usb_rx_o,
  output hslm_sym_s [3:0]         sgmii_rx_o
);

  hslm_route_s [3:0]                  route;
  hslm_sym_s [`HSLM_SRC_COUNT-1:0]    src_tx;
  hslm_sym_s [3:0]                    next_lane_tx;
  hslm_sym_s [`HSLM_SRC_COUNT-1:0]    next_rx;
  hslm_sym_s [`HSLM_SRC_COUNT-1:0]    rx_q;
  hslm_sym_s [3:0]                    lane_tx_q;

  // display has no receive return; its slots stay idle
  assign src_tx = {sgmii_tx_i, usb_tx_i, disp_tx_i, sata_tx_i, pcie_tx_i};

  for (genvar l = 0; l < `HSLM_LANES; l++) begin : g_lane
    hslm_lane_sel #(
      .LANE (l)
    ) u_sel (
      .sel_i        (lane_sel_i[l]),
      .pcie_width_i (pcie_width_i),
      .route_o      (route[l])
    );
  end

  // each lane picks its own source, so any mix runs side by side
  always_comb begin
    for (int l = 0; l < `HSLM_LANES; l++) begin
      next_lane_tx[l] = '0;
      if (route[l].ok) begin
        next_lane_tx[l] = src_tx[route[l].src];
      end
    end
  end

  // two lanes may claim one sink (sata on 0 and 2); lowest lane wins
  always_comb begin
    for (int j = 0; j < `HSLM_SRC_COUNT; j++) begin
      next_rx[j] = '0;
      for (int l = `HSLM_LANES - 1; l >= 0; l--) begin
        if (route[l].ok && route[l].rx_ok &&
            route[l].src == `HSLM_SRC_W'(j)) begin
          next_rx[j] = lane_rx_i[l];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      lane_tx_q <= '0;
      rx_q      <= '0;
    end else begin
      lane_tx_q <= next_lane_tx;
      rx_q      <= next_rx;
    end
  end

  assign lane_tx_o  = lane_tx_q;
  assign pcie_rx_o  = rx_q[3:0];
  assign sata_rx_o  = rx_q[5:4];
  assign usb_rx_o   = rx_q[9:8];
  assign sgmii_rx_o = rx_q[13:10];

  for (genvar l = 0; l < `HSLM_LANES; l++) begin : g_chk
    localparam int PAR = l % 2;

    lane_idle_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      !route[l].ok |=> lane_tx_o[l] == '0)
      else $error("unrouted lane not idle");

    pcie_place_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (lane_sel_i[l] == HSLM_SEL_PCIE &&
       l < int'(hslm_pcie_lanes(pcie_width_i)))
      |=> lane_tx_o[l] == $past(pcie_tx_i[l]))
      else $error("pcie lane misplaced");

    pcie_width_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (lane_sel_i[l] == HSLM_SEL_PCIE &&
       l >= int'(hslm_pcie_lanes(pcie_width_i)))
      |=> lane_tx_o[l] == '0)
      else $error("pcie lane beyond width not idle");

    sata_place_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      lane_sel_i[l] == HSLM_SEL_SATA
      |=> lane_tx_o[l] == $past(sata_tx_i[PAR]))
      else $error("sata channel on wrong lane");

    disp_place_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      lane_sel_i[l] == HSLM_SEL_DISP
      |=> lane_tx_o[l] == $past(disp_tx_i[1 - PAR]))
      else $error("display lane on wrong lane");

    usb0_lane_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      lane_sel_i[l] == HSLM_SEL_USB0
      |=> lane_tx_o[l] == ((l == 3) ? '0 : $past(usb_tx_i[0])))
      else $error("first usb routing wrong");

    usb1_lane_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      lane_sel_i[l] == HSLM_SEL_USB1
      |=> lane_tx_o[l] == ((l == 3) ? $past(usb_tx_i[1]) : '0))
      else $error("second usb routing wrong");

    sgmii_place_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      lane_sel_i[l] == HSLM_SEL_SGMII
      |=> lane_tx_o[l] == $past(sgmii_tx_i[l]))
      else $error("sgmii port on wrong lane");

    sgmii_rx_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      lane_sel_i[l] == HSLM_SEL_SGMII
      |=> sgmii_rx_o[l] == $past(lane_rx_i[l]))
      else $error("sgmii receive not returned");

    pcie_rx_lane_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (lane_sel_i[l] == HSLM_SEL_PCIE &&
       l < int'(hslm_pcie_lanes(pcie_width_i)))
      |=> pcie_rx_o[l] == $past(lane_rx_i[l]))
      else $error("pcie receive not returned");

    sgmii_none_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      lane_sel_i[l] != HSLM_SEL_SGMII |=> sgmii_rx_o[l] == '0)
      else $error("sgmii receive from foreign lane");
  end

  pcie_rx_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (lane_sel_i[0] == HSLM_SEL_PCIE && pcie_width_i != 2'h3)
    |=> pcie_rx_o[0] == $past(lane_rx_i[0]))
    else $error("pcie lane 0 receive lost");

  sata_none_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (lane_sel_i[0] != HSLM_SEL_SATA && lane_sel_i[2] != HSLM_SEL_SATA)
    |=> sata_rx_o[0] == '0)
    else $error("sata receive leaked from unrouted lane");

  sata_rx_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    lane_sel_i[0] == HSLM_SEL_SATA
    |=> sata_rx_o[0] == $past(lane_rx_i[0]))
    else $error("sata channel 0 receive lost");

  sata1_none_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (lane_sel_i[1] != HSLM_SEL_SATA && lane_sel_i[3] != HSLM_SEL_SATA)
    |=> sata_rx_o[1] == '0)
    else $error("sata channel 1 receive leaked");

  usb0_rx_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (lane_sel_i[0] != HSLM_SEL_USB0 && lane_sel_i[1] != HSLM_SEL_USB0 &&
     lane_sel_i[2] != HSLM_SEL_USB0)
    |=> usb_rx_o[0] == '0)
    else $error("first usb receive from lane 3");

  usb1_rx_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    lane_sel_i[3] == HSLM_SEL_USB1
    |=> usb_rx_o[1] == $past(lane_rx_i[3]))
    else $error("second usb receive lost");

  usb1_none_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    lane_sel_i[3] != HSLM_SEL_USB1 |=> usb_rx_o[1] == '0)
    else $error("second usb receive off lane 3");

  pcie_off_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    pcie_width_i == 2'h3 |=> pcie_rx_o == '0)
    else $error("disabled pcie still receives");

  pcie_x4_c: cover property (
    @(posedge clk_i) disable iff (!nrst_i)
    pcie_width_i == `HSLM_WIDTH_X4 &&
    lane_sel_i == {4{HSLM_SEL_PCIE}});

  sata_dual_c: cover property (
    @(posedge clk_i) disable iff (!nrst_i)
    lane_sel_i[2] == HSLM_SEL_SATA && lane_sel_i[3] == HSLM_SEL_SATA);

  mixed_c: cover property (
    @(posedge clk_i) disable iff (!nrst_i)
    lane_sel_i[0] == HSLM_SEL_PCIE && lane_sel_i[1] == HSLM_SEL_DISP &&
    lane_sel_i[2] == HSLM_SEL_USB0 && lane_sel_i[3] == HSLM_SEL_SGMII);

  reselect_c: cover property (
    @(posedge clk_i) disable iff (!nrst_i)
    $changed(lane_sel_i[3]) && lane_sel_i[3] == HSLM_SEL_USB1);

  usb0_lane3_c: cover property (
    @(posedge clk_i) disable iff (!nrst_i)
    lane_sel_i[3] == HSLM_SEL_USB0);

endmodule : hslm_top

// ==== test/hslm_lane_model.sv ====
// Purpose: transceiver lane model that returns receive symbols
// Assumes: shares the mux clock
// Notes:   pattern moves every cycle so a stale receive path shows
module hslm_lane_model
  import hslm_pkg::*;
(
  input  wire logic            clk_i,
  input  wire hslm_sym_s [3:0] lane_tx_i,
  output hslm_sym_s [3:0]      lane_rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt = 16'h0000;
  initial lane_rx_o = '0;
  // tx is only consumed by the line; nothing loops back
  always @(posedge clk_i) begin
    cnt <= cnt + 16'h0001;
    for (int l = 0; l < 4; l++) begin
      lane_rx_o[l] <= '{vld: 1'b1, dat: {l[3:0], cnt}};
    end
  end
endmodule : hslm_lane_model

// ==== test/testbench.sv ====
// Purpose: self-checking bench of the lane multiplexer
// Assumes: one cycle latency each way, idle symbol all zero
// Notes:   lane selection or pcie width changes from one table row to the next to catch stale registers
module testbench
  import hslm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] sel;
    logic [1:0]  w;
    logic [31:0] e;
  } hslm_row_s;
  logic            clk_i = 1'b0;
  logic            nrst_i = 1'b0;
  hslm_sel_e [3:0] lane_sel = '{4{HSLM_SEL_NONE}};
  logic [1:0]      pcie_width = 2'h0;
  hslm_sym_s [3:0] pcie_tx = '0, sgmii_tx = '0, lane_rx, lane_tx, snap;
  hslm_sym_s [1:0] sata_tx = '0, disp_tx = '0, usb_tx = '0;
  hslm_sym_s [3:0] pcie_rx, sgmii_rx;
  hslm_sym_s [1:0] sata_rx, usb_rx;
  int              miscompares = 0;
  int              comparisons = 0;
  int              cycles = 0;
  logic [7:0]      slots [12] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h20,
    8'h21, 8'h40, 8'h41, 8'h50, 8'h51, 8'h52, 8'h53};
  hslm_row_s       rows [12] = '{
    '{16'h0000, 2'h0, 32'h00000000},
    '{16'h1111, 2'h2, 32'h13121110},
    '{16'h1111, 2'h1, 32'h00001110},
    '{16'h1111, 2'h0, 32'h00000010},
    '{16'h1111, 2'h3, 32'h00000000},
    '{16'h2222, 2'h0, 32'h21202120},
    '{16'h3333, 2'h0, 32'h30313031},
    '{16'h4444, 2'h0, 32'h00404040},
    '{16'h5555, 2'h0, 32'h41000000},
    '{16'h6666, 2'h0, 32'h53525150},
    '{16'h3426, 2'h0, 32'h30402150},
    '{16'h5231, 2'h0, 32'h41203010}};

  hslm_top i_hslm_top (.clk_i(clk_i), .nrst_i(nrst_i),
    .lane_sel_i(lane_sel), .pcie_width_i(pcie_width),
    .pcie_tx_i(pcie_tx), .sata_tx_i(sata_tx), .disp_tx_i(disp_tx),
    .usb_tx_i(usb_tx), .sgmii_tx_i(sgmii_tx), .lane_rx_i(lane_rx),
    .lane_tx_o(lane_tx), .pcie_rx_o(pcie_rx), .sata_rx_o(sata_rx),
    .usb_rx_o(usb_rx), .sgmii_rx_o(sgmii_rx));
  hslm_lane_model i_hslm_lane_model (.clk_i(clk_i),
    .lane_tx_i(lane_tx), .lane_rx_o(lane_rx));

  always #4 clk_i = ~clk_i;

  function automatic hslm_sym_s sym(input logic [3:0] p,
                                    input logic [3:0] i, input int k);
    sym = '{vld: 1'b1, dat: {p, k[7:0], 4'h0, i}};
  endfunction : sym

  function automatic hslm_sym_s rx_of(input logic [7:0] c);
    case (c[7:4])
      4'h1: rx_of = pcie_rx[c[1:0]];
      4'h2: rx_of = sata_rx[c[0]];
      4'h4: rx_of = usb_rx[c[0]];
      default: rx_of = sgmii_rx[c[1:0]];
    endcase
  endfunction : rx_of

  task finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check(input hslm_sym_s got, input hslm_sym_s exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // static on purpose: nonblocking targets indexed by the loop variable
  task apply(input hslm_row_s r, input int k);
    for (int l = 0; l < 4; l++) begin
      lane_sel[l] <= hslm_sel_e'(r.sel[4*l +: 3]);
      pcie_tx[l]  <= sym(4'h1, l[3:0], k);
      sgmii_tx[l] <= sym(4'h5, l[3:0], k);
      if (l < 2) begin
        sata_tx[l] <= sym(4'h2, l[3:0], k);
        disp_tx[l] <= sym(4'h3, l[3:0], k);
        usb_tx[l]  <= sym(4'h4, l[3:0], k);
      end
    end
    pcie_width <= r.w;
  endtask : apply

  // lowest lane wins a shared receive slot, so scan from the top down
  task automatic verify(input hslm_row_s r, input int k);
    hslm_sym_s exp;
    for (int s = 0; s < 12; s++) begin
      exp = '0;
      for (int l = 3; l >= 0; l--) begin
        if (r.e[8*l +: 8] === slots[s]) exp = snap[l];
      end
      check(rx_of(slots[s]), exp);
    end
    for (int l = 0; l < 4; l++) begin
      exp = '0;
      if (r.e[8*l +: 8] != 8'h00) exp = sym(r.e[8*l+4 +: 4], r.e[8*l +: 4], k);
      check(lane_tx[l], exp);
    end
  endtask : verify

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 200) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int k = 0; k <= 12; k++) begin
      @(posedge clk_i);
      if (k < 12) apply(rows[k], k + 1);
      #1;
      if (k > 0) verify(rows[k-1], k);
      @(negedge clk_i);
      snap = lane_rx;
    end
    $display("test routing table done");
    @(posedge clk_i);
    nrst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    verify('0, 0);
    @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    snap = lane_rx;
    @(posedge clk_i);
    #1;
    verify(rows[11], 12);
    $display("test reset done");
    finish_test();
  end
endmodule : testbench
